// >>> rtc_pkg.sv
// shared constants and types for the bus calendar core
package rtc_pkg;
	// timing, each in its own unit, then in clock cycles
	localparam int CLK_HZ     = 125_000_000;
	localparam int SEC_MS     = 1000;
	localparam int RCL_MS     = 100;
	localparam int UIP_US     = 244;
	localparam int TAP_HZ     = 32768;
	localparam int SEC_CYCLES = SEC_MS * (CLK_HZ / 1000);
	localparam int RCL_CYCLES = RCL_MS * (CLK_HZ / 1000);
	localparam int UIP_CYCLES = UIP_US * (CLK_HZ / 1_000_000);
	localparam int TAP_CYCLES = CLK_HZ / TAP_HZ;
	// location map
	localparam logic [6:0] OFS_SEC    = 7'h00;
	localparam logic [6:0] OFS_SEC_AL = 7'h01;
	localparam logic [6:0] OFS_MIN    = 7'h02;
	localparam logic [6:0] OFS_MIN_AL = 7'h03;
	localparam logic [6:0] OFS_HR     = 7'h04;
	localparam logic [6:0] OFS_HR_AL  = 7'h05;
	localparam logic [6:0] OFS_WDAY   = 7'h06;
	localparam logic [6:0] OFS_DATE   = 7'h07;
	localparam logic [6:0] OFS_MONTH  = 7'h08;
	localparam logic [6:0] OFS_YEAR   = 7'h09;
	localparam logic [6:0] OFS_CTRL_A = 7'h0a;
	localparam logic [6:0] OFS_CTRL_B = 7'h0b;
	localparam logic [6:0] OFS_CTRL_C = 7'h0c;
	localparam logic [6:0] OFS_CTRL_D = 7'h0d;
	localparam logic [6:0] OFS_RAM    = 7'h0e;
	localparam int         RAM_BYTES  = 114;
	// field positions
	localparam int A_UIP  = 7;
	localparam int B_SET  = 7;
	localparam int B_PIE  = 6;
	localparam int B_AIE  = 5;
	localparam int B_UIE  = 4;
	localparam int B_SQUARE_WAVE_ENABLE = 3;
	localparam int B_DM   = 2;
	localparam int B_24H  = 1;
	localparam int D_VRT  = 7;
	// reset and fixed values
	localparam logic [6:0] CTRL_A_RST = 7'h26;
	localparam logic [7:0] CTRL_B_RST = 8'h02;
	localparam logic [7:0] RAM_FILL   = 8'hff;
	localparam logic [2:0] DV_RUN     = 3'h2;
	localparam logic [1:0] ALARM_ANY  = 2'h3;

	typedef enum logic [1:0] {
		CLR_IDLE  = 2'b00,
		CLR_ARMED = 2'b01,
		CLR_FILL  = 2'b11,
		CLR_DONE  = 2'b10
	} clr_state_t;

	typedef struct packed {
		logic pf;
		logic af;
		logic uf;
	} event_t;

	typedef struct packed {
		logic [2:0]      as_p;
		logic [2:0]      ds_p;
		logic [2:0]      rw_p;
		logic [1:0]      rst_p;
		logic [1:0]      rcl_p;
		logic [6:0]      addr;
		logic [7:0]      wdata;
		logic            ce_seen;
		logic [9:0][7:0] tm;
		logic [6:0]      reg_a;
		logic [7:0]      reg_b;
		event_t          flags;
		logic [7:0]      dq_out;
		logic            dq_oe;
		logic            square_wave_out;
		logic            tap_q;
		logic [31:0]     pre_cnt;
		logic [15:0]     div;
		logic [31:0]     sec_cnt;
		clr_state_t      clr;
		logic [31:0]     rcl_cnt;
		logic [6:0]      clr_idx;
	} state_t;
endpackage

// >>> rtc_bus_calendar_core.sv
// clock and calendar core with a multiplexed byte bus
//
// Notes on behaviour
// - square-wave pin follows one of 13 divider taps, gated by its enable bit.
// - address on the shared lines is captured on the address strobe falling edge.
// - reads drive eight bits from the strobe's leading edge and release at its end.
// - bus-style pin high picks one strobe convention, low the other.
// - read drivers switch on at the data strobe falling edge with the style pin low, at its rising edge with it high.
// - without chip enable the address is still latched but no data moves.
// - interrupt pin is pulled low while any flag meets its enable bit.
// - reading the third control register lets the interrupt pin float.
// - reset pin low clears periodic, alarm, update and square-wave enables.
// - reset pin low clears all event flags and floats the interrupt pin.
// - bus accesses are ignored while the reset pin is low.
// - clear pin low for 100 ms while the oscillator runs fills all 114 user bytes with ff.
// - map: ten time bytes, four control bytes, 114 user bytes.
// - third and fourth control registers and first register bit 7 are read-only.
// - seconds, minutes, weekday, date, month and year ranges per data format.
// - twelve-hour mode uses hour bit 7 as afternoon; 24-hour spans 0 to 23.
// - once a second time advances, then alarm bytes are compared.
// - update-inhibit bit stops time advance while host sets the clock.
// - data-format bit picks binary or BCD for every update.
// - hour-format bit picks 12 or 24 hour counting.
// - time and user bytes stay accessible during an update.
// - event flags are set regardless of their enable bits.
`timescale 1ns/1ps
module rtc_bus_calendar_core #(
	parameter int SEC_CYC = rtc_pkg::SEC_CYCLES,
	parameter int RCL_CYC = rtc_pkg::RCL_CYCLES,
	parameter int UIP_CYC = rtc_pkg::UIP_CYCLES
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	// multiplexed bus
	input  wire logic [7:0] shared_addr_data_lines_i,
	output logic      [7:0] shared_addr_data_lines_o,
	output logic            shared_addr_data_lines_oe_o,
	input  wire logic       address_latch_strobe_i,
	input  wire logic       data_read_strobe_i,
	input  wire logic       read_write_i,
	input  wire logic       chip_enable_n_i,
	input  wire logic       bus_style_select_i,
	// control pins
	input  wire logic       device_reset_n_i,
	input  wire logic       user_ram_clear_n_i,
	// outputs, plus the interrupt pin input
	output logic            square_wave_out_o,
	input  wire logic       irq_req_i,
	output logic            irq_req_o,
	output logic            irq_req_oe_o
);
	rtc_pkg::state_t st_r;
	rtc_pkg::state_t st_nxt;
	rtc_pkg::event_t ev;
	logic [7:0]      ram [rtc_pkg::RAM_BYTES];
	logic            ram_we;
	logic [6:0]      ram_wa;
	logic [7:0]      ram_wd;
	logic [7:0]      ram_q;
	logic [7:0]      rd_mux;
	logic            bus_style_select, as_fall, ds_rise, ds_fall, rw_rise;
	logic            rd_go, rd_stop, wr_go, wcap, dev_rst, acc_ok;
	logic            osc_run, tick, upd, uip, irq_summary_flag, tap_now, alarm_hit;
	logic [9:0][7:0] tm_adv;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	function automatic logic [7:0] to_num(input logic [7:0] v, input logic b);
		return b ? v : 8'({4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]});
	endfunction

	function automatic logic [7:0] to_code(input logic [7:0] n, input logic b);
		logic [7:0] t;
		t = n / 8'h0a;
		return b ? n : {t[3:0], 4'(n - 8'(t * 8'h0a))};
	endfunction

	function automatic logic [7:0] month_days(input logic [7:0] mo, input logic [7:0] yr);
		case (mo)
			8'h02: return (yr[1:0] == 2'h0) ? 8'h1d : 8'h1c;
			8'h04, 8'h06, 8'h09, 8'h0b: return 8'h1e;
			default: return 8'h1f;
		endcase
	endfunction

	function automatic logic tap_bit(input logic [3:0] rate, input logic [15:0] dv);
		case (rate)
			4'h0: return 1'b0;
			4'h1: return dv[6];
			4'h2: return dv[7];
			default: return dv[4'(rate - 4'h2)];
		endcase
	endfunction

	function automatic logic al_match(input logic [7:0] al, input logic [7:0] now);
		return (al[7:6] == rtc_pkg::ALARM_ANY) || (al == now);
	endfunction

	// strobe edges come from the second and third synchroniser stages
	assign as_fall = st_r.as_p[2] & ~st_r.as_p[1];
	assign ds_rise = ~st_r.ds_p[2] & st_r.ds_p[1];
	assign ds_fall = st_r.ds_p[2] & ~st_r.ds_p[1];
	assign rw_rise = ~st_r.rw_p[2] & st_r.rw_p[1];
	assign dev_rst = ~st_r.rst_p[1];
	// style pin high: strobe plus direction; low: separate read and write strobes
	assign bus_style_select = bus_style_select_i;
	// in read-strobe style the falling edge starts the drive
	assign rd_go   = bus_style_select ? (ds_rise & st_r.rw_p[1]) : ds_fall;
	assign rd_stop = bus_style_select ? ds_fall : (ds_rise | rw_rise);
	assign wr_go   = bus_style_select ? (ds_fall & ~st_r.rw_p[1]) : rw_rise;
	// data is captured from the pins while the write strobe is still active
	assign wcap    = bus_style_select ? (data_read_strobe_i & ~read_write_i) : ~read_write_i;
	// data moves only when chip enable was seen during the strobe
	assign acc_ok  = st_r.ce_seen & ~dev_rst;

	assign osc_run = st_r.reg_a[6:4] == rtc_pkg::DV_RUN;
	assign tick    = osc_run && (st_r.sec_cnt == 32'(SEC_CYC - 1));
	// the inhibit bit holds the time bytes
	assign upd     = tick & ~st_r.reg_b[rtc_pkg::B_SET];
	assign uip     = osc_run & ~st_r.reg_b[rtc_pkg::B_SET] & (st_r.sec_cnt >= 32'(SEC_CYC - UIP_CYC));
	assign tap_now = tap_bit(st_r.reg_a[3:0], st_r.div);
	// any flag with its enable pulls the pin low
	assign irq_summary_flag    = |(st_r.flags & st_r.reg_b[rtc_pkg::B_PIE:rtc_pkg::B_UIE]);

	assign ram_q = (st_r.addr >= rtc_pkg::OFS_RAM) ? ram[st_r.addr - rtc_pkg::OFS_RAM] : 8'h00;

	// read decode, control registers at 10 to 13
	always_comb begin
		case (st_r.addr)
			rtc_pkg::OFS_CTRL_A: rd_mux = {uip, st_r.reg_a};
			rtc_pkg::OFS_CTRL_B: rd_mux = st_r.reg_b;
			rtc_pkg::OFS_CTRL_C: rd_mux = {irq_summary_flag, st_r.flags, 4'h0};
			rtc_pkg::OFS_CTRL_D: rd_mux = 8'(1 << rtc_pkg::D_VRT);
			default: begin
				// user and time bytes are read without waiting on updates
				rd_mux = (st_r.addr < rtc_pkg::OFS_CTRL_A) ? st_r.tm[st_r.addr[3:0]] : ram_q;
			end
		endcase
	end

	// time advance, one second at a time
	always_comb begin
		logic       b, pm, c_h, c_d, c_mo, c_y;
		logic [7:0] s0, m0, h0, hh, wd0, dt0, mo0, yr0, h12;
		b      = st_r.reg_b[rtc_pkg::B_DM];
		h0     = 8'h00;
		tm_adv = st_r.tm;
		s0     = to_num(st_r.tm[rtc_pkg::OFS_SEC], b);
		m0     = to_num(st_r.tm[rtc_pkg::OFS_MIN], b);
		wd0    = st_r.tm[rtc_pkg::OFS_WDAY];
		dt0    = to_num(st_r.tm[rtc_pkg::OFS_DATE], b);
		mo0    = to_num(st_r.tm[rtc_pkg::OFS_MONTH], b);
		yr0    = to_num(st_r.tm[rtc_pkg::OFS_YEAR], b);
		pm     = st_r.tm[rtc_pkg::OFS_HR][7];
		hh     = to_num({1'b0, st_r.tm[rtc_pkg::OFS_HR][6:0]}, b);
		// hours are counted internally as 0 to 23
		if (st_r.reg_b[rtc_pkg::B_24H]) begin
			h0 = to_num(st_r.tm[rtc_pkg::OFS_HR], b);
		end else begin
			h0 = (hh == 8'h0c) ? (pm ? 8'h0c : 8'h00) : (pm ? hh + 8'h0c : hh);
		end
		// seconds and minutes wrap at 59
		c_h  = (s0 == 8'h3b) && (m0 == 8'h3b);
		c_d  = c_h && (h0 == 8'h17);
		c_mo = c_d && (dt0 >= month_days(mo0, yr0));
		c_y  = c_mo && (mo0 >= 8'h0c);
		s0   = (s0 == 8'h3b) ? 8'h00 : s0 + 8'h01;
		if (s0 == 8'h00) begin
			m0 = (m0 == 8'h3b) ? 8'h00 : m0 + 8'h01;
		end
		if (c_h) begin
			h0 = (h0 == 8'h17) ? 8'h00 : h0 + 8'h01;
		end
		if (c_d) begin
			wd0 = (wd0 >= 8'h07) ? 8'h01 : wd0 + 8'h01;
			dt0 = c_mo ? 8'h01 : dt0 + 8'h01;
		end
		if (c_mo) begin
			mo0 = c_y ? 8'h01 : mo0 + 8'h01;
		end
		if (c_y) begin
			yr0 = (yr0 == 8'h63) ? 8'h00 : yr0 + 8'h01;
		end
		// every byte is written back in the selected format
		tm_adv[rtc_pkg::OFS_SEC]   = to_code(s0, b);
		tm_adv[rtc_pkg::OFS_MIN]   = to_code(m0, b);
		tm_adv[rtc_pkg::OFS_WDAY]  = wd0;
		tm_adv[rtc_pkg::OFS_DATE]  = to_code(dt0, b);
		tm_adv[rtc_pkg::OFS_MONTH] = to_code(mo0, b);
		tm_adv[rtc_pkg::OFS_YEAR]  = to_code(yr0, b);
		// twelve-hour mode puts the afternoon flag in bit 7
		h12 = (h0 >= 8'h0c) ? h0 - 8'h0c : h0;
		h12 = (h12 == 8'h00) ? 8'h0c : h12;
		h12 = to_code(h12, b);
		if (st_r.reg_b[rtc_pkg::B_24H]) begin
			tm_adv[rtc_pkg::OFS_HR] = to_code(h0, b);
		end else begin
			tm_adv[rtc_pkg::OFS_HR] = {h0 >= 8'h0c, h12[6:0]};
		end
		// alarm is compared against the advanced time
		alarm_hit = al_match(st_r.tm[rtc_pkg::OFS_SEC_AL], tm_adv[rtc_pkg::OFS_SEC])
			&& al_match(st_r.tm[rtc_pkg::OFS_MIN_AL], tm_adv[rtc_pkg::OFS_MIN])
			&& al_match(st_r.tm[rtc_pkg::OFS_HR_AL], tm_adv[rtc_pkg::OFS_HR]);
	end

	// events raise flags whatever the enables say
	always_comb begin
		ev.pf = tap_now & ~st_r.tap_q;
		ev.af = upd & alarm_hit;
		ev.uf = upd;
	end

	always_comb begin
		st_nxt = st_r;
		ram_we = 1'b0;
		ram_wa = 7'h00;
		ram_wd = 8'h00;
		// two-stage synchronisers, plus an edge stage on strobe and direction
		st_nxt.as_p  = {st_r.as_p[1:0], address_latch_strobe_i};
		st_nxt.ds_p  = {st_r.ds_p[1:0], data_read_strobe_i};
		st_nxt.rw_p  = {st_r.rw_p[1:0], read_write_i};
		st_nxt.rst_p = {st_r.rst_p[0], device_reset_n_i};
		st_nxt.rcl_p = {st_r.rcl_p[0], user_ram_clear_n_i};
		if (wcap) begin
			st_nxt.wdata = shared_addr_data_lines_i;
		end
		if ((bus_style_select ? data_read_strobe_i : (~data_read_strobe_i | ~read_write_i)) && !chip_enable_n_i) begin
			st_nxt.ce_seen = 1'b1;
		end
		// timebase: tap prescaler, tap divider and one-second counter
		st_nxt.tap_q = tap_now;
		if (!osc_run) begin
			st_nxt.pre_cnt = 32'h0;
			st_nxt.div     = 16'h0;
			st_nxt.sec_cnt = 32'h0;
		end else begin
			st_nxt.pre_cnt = (st_r.pre_cnt == 32'(rtc_pkg::TAP_CYCLES - 1)) ? 32'h0 : st_r.pre_cnt + 32'h1;
			if (st_r.pre_cnt == 32'(rtc_pkg::TAP_CYCLES - 1)) begin
				st_nxt.div = st_r.div + 16'h1;
			end
			st_nxt.sec_cnt = tick ? 32'h0 : st_r.sec_cnt + 32'h1;
		end
		// square wave gated by its enable
		st_nxt.square_wave_out = st_r.reg_b[rtc_pkg::B_SQUARE_WAVE_ENABLE] & tap_now;
		// one-second advance of the time bytes
		if (upd) begin
			st_nxt.tm = tm_adv;
		end
		// reset pin blocks the bus and clears enables and flags
		if (dev_rst) begin
			st_nxt.reg_b[rtc_pkg::B_PIE:rtc_pkg::B_SQUARE_WAVE_ENABLE] = 4'h0;
			st_nxt.flags = '0;
			st_nxt.dq_oe = 1'b0;
		end else begin
			// address captured on the falling strobe edge
			if (as_fall) begin
				st_nxt.addr    = shared_addr_data_lines_i[6:0];
				st_nxt.ce_seen = 1'b0;
			end
			// read data comes from a flop, released at the end of the strobe
			if (rd_stop) begin
				st_nxt.dq_oe = 1'b0;
			end
			if (rd_go && acc_ok) begin
				st_nxt.dq_out = rd_mux;
				st_nxt.dq_oe  = 1'b1;
				// reading the third register clears the flags
				if (st_r.addr == rtc_pkg::OFS_CTRL_C) begin
					st_nxt.flags = '0;
				end
			end
			if (wr_go && acc_ok) begin
				// read-only locations and bit 7 of the first register ignore writes
				case (st_r.addr)
					rtc_pkg::OFS_CTRL_A: st_nxt.reg_a = st_r.wdata[6:0];
					rtc_pkg::OFS_CTRL_B: st_nxt.reg_b = st_r.wdata;
					rtc_pkg::OFS_CTRL_C, rtc_pkg::OFS_CTRL_D: st_nxt.reg_b = st_nxt.reg_b;
					default: begin
						if (st_r.addr < rtc_pkg::OFS_CTRL_A) begin
							st_nxt.tm[st_r.addr[3:0]] = st_r.wdata;
						end else begin
							// user bytes are writable at any time except while the clear fill runs
							ram_we = 1'b1;
							ram_wa = st_r.addr - rtc_pkg::OFS_RAM;
							ram_wd = st_r.wdata;
						end
					end
				endcase
			end
			// a new event wins over a clear in the same cycle
			st_nxt.flags = st_nxt.flags | ev;
		end
		// clear pin held low long enough with the oscillator running fills the user bytes
		case (st_r.clr)
			rtc_pkg::CLR_IDLE: begin
				st_nxt.rcl_cnt = 32'h0;
				if (!st_r.rcl_p[1] && osc_run) begin
					st_nxt.clr = rtc_pkg::CLR_ARMED;
				end
			end
			rtc_pkg::CLR_ARMED: begin
				st_nxt.rcl_cnt = st_r.rcl_cnt + 32'h1;
				st_nxt.clr_idx = 7'h00;
				if (st_r.rcl_p[1] || !osc_run) begin
					st_nxt.clr = rtc_pkg::CLR_IDLE;
				end else if (st_r.rcl_cnt == 32'(RCL_CYC - 1)) begin
					st_nxt.clr = rtc_pkg::CLR_FILL;
				end
			end
			rtc_pkg::CLR_FILL: begin
				ram_we         = 1'b1;
				ram_wa         = st_r.clr_idx;
				ram_wd         = rtc_pkg::RAM_FILL;
				st_nxt.clr_idx = st_r.clr_idx + 7'h01;
				if (st_r.clr_idx == 7'(rtc_pkg::RAM_BYTES - 1)) begin
					st_nxt.clr = rtc_pkg::CLR_DONE;
				end
			end
			rtc_pkg::CLR_DONE: begin
				if (st_r.rcl_p[1]) begin
					st_nxt.clr = rtc_pkg::CLR_IDLE;
				end
			end
			default: st_nxt.clr = rtc_pkg::CLR_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r       <= '0;
			st_r.as_p  <= 3'h0;
			st_r.ds_p  <= 3'h7;
			st_r.rw_p  <= 3'h7;
			st_r.rcl_p <= 2'h3;
			st_r.reg_a <= rtc_pkg::CTRL_A_RST;
			st_r.reg_b <= rtc_pkg::CTRL_B_RST;
			st_r.clr   <= rtc_pkg::CLR_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// user bytes keep no reset value
	always_ff @(posedge clk_i) begin
		if (ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
	end

	assign shared_addr_data_lines_o    = st_r.dq_out;
	assign shared_addr_data_lines_oe_o = st_r.dq_oe;
	assign square_wave_out_o           = st_r.square_wave_out;
	assign irq_req_o                   = 1'b0;
	assign irq_req_oe_o                = irq_summary_flag;

	sqw_gate_a: assert property (!st_r.reg_b[rtc_pkg::B_SQUARE_WAVE_ENABLE] |=> !square_wave_out_o)
		else $error("square wave active while disabled");
	addr_latch_a: assert property (as_fall && !dev_rst |=> st_r.addr == $past(shared_addr_data_lines_i[6:0]))
		else $error("address not latched on strobe fall");
	read_drive_a: assert property (rd_go && acc_ok |=> shared_addr_data_lines_oe_o
		&& shared_addr_data_lines_o == $past(rd_mux))
		else $error("read data not driven");
	ce_gate_a: assert property (rd_go && !acc_ok && !st_r.dq_oe |=> !shared_addr_data_lines_oe_o)
		else $error("bus driven without chip enable");
	irq_event_a: assert property (ev.af && st_r.reg_b[rtc_pkg::B_AIE] && !dev_rst |=> irq_req_oe_o)
		else $error("alarm did not raise interrupt");
	read_c_clear_a: assert property (rd_go && acc_ok && st_r.addr == rtc_pkg::OFS_CTRL_C
		&& ev == '0 |=> !irq_req_oe_o)
		else $error("interrupt kept after status read");
	rst_enables_a: assert property (dev_rst |=> st_r.reg_b[rtc_pkg::B_PIE:rtc_pkg::B_SQUARE_WAVE_ENABLE] == 4'h0)
		else $error("enables survive reset pin");
	rst_flags_a: assert property (dev_rst |=> st_r.flags == '0 && !irq_req_oe_o)
		else $error("flags survive reset pin");
	rst_no_bus_a: assert property (dev_rst |=> !shared_addr_data_lines_oe_o ##1 !shared_addr_data_lines_oe_o)
		else $error("bus driven during reset pin");
	ro_status_a: assert property (wr_go && acc_ok && st_r.addr == rtc_pkg::OFS_CTRL_C && ev == '0
		|=> st_r.flags == $past(st_r.flags))
		else $error("status register changed by write");
	inhibit_hold_a: assert property (st_r.reg_b[rtc_pkg::B_SET] && !(wr_go && acc_ok) |=> $stable(st_r.tm))
		else $error("time advanced while inhibited");
	fill_ff_a: assert property (st_r.clr == rtc_pkg::CLR_FILL |-> ram_we && ram_wd == rtc_pkg::RAM_FILL)
		else $error("clear does not write fill value");

	read_seen_c: cover property (rd_go && acc_ok ##[1:20] rd_stop);
	write_seen_c: cover property (wr_go && acc_ok);
	alarm_seen_c: cover property (ev.af ##1 irq_req_oe_o);
	fill_done_c: cover property (st_r.clr == rtc_pkg::CLR_FILL ##113 st_r.clr == rtc_pkg::CLR_DONE);
endmodule

// >>> rtc_host_model.sv
// host processor model that drives the multiplexed bus
`timescale 1ns/1ps
module rtc_host_model (
	// clock
	input  wire logic       clk_i,
	// device side of the shared lines
	input  wire logic [7:0] dev_d_i,
	input  wire logic       dev_oe_i,
	// host outputs
	output logic      [7:0] bus_o,
	output logic            style_o,
	output logic            as_o,
	output logic            ds_o,
	output logic            rw_o,
	output logic            ce_n_o
);
	logic [7:0] drv = 8'h00;
	logic       drv_on = 1'b0;
	logic [7:0] last = 8'h00;
	initial begin
		style_o = 1'b0;
		as_o = 1'b0;
		ds_o = 1'b1;
		rw_o = 1'b1;
		ce_n_o = 1'b1;
	end
	// undriven lines show the inverse of the last value
	always_comb begin
		if (dev_oe_i === 1'b1)
			bus_o = dev_d_i;
		else if (drv_on)
			bus_o = drv;
		else
			bus_o = ~last;
	end
	always_ff @(posedge clk_i) last <= bus_o;
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// switch bus style with strobes parked idle
	task automatic set_style(input logic s);
		style_o = s;
		ds_o = ~s;
		wait_n(8);
	endtask
	task automatic access(input logic wr, input logic ce, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic got);
		int k;
		got = 1'b0;
		q = 8'h00;
		drv = {1'b0, a};
		drv_on = 1'b1;
		as_o = 1'b1;
		wait_n(4);
		as_o = 1'b0;
		wait_n(4);
		ce_n_o = ~ce;
		if (style_o) rw_o = ~wr;
		drv = d;
		drv_on = wr;
		if (wr) begin
			// data held through the write strobe
			if (style_o) ds_o = 1'b1; else rw_o = 1'b0;
			wait_n(5);
			if (style_o) ds_o = 1'b0; else rw_o = 1'b1;
			wait_n(5);
		end else begin
			ds_o = style_o;
			for (k = 0; k < 12 && !got; k++) begin
				@(posedge clk_i);
				if (dev_oe_i === 1'b1) begin
					got = 1'b1;
					q = bus_o;
				end
			end
			wait_n(2);
			ds_o = ~style_o;
			for (k = 0; k < 12 && dev_oe_i !== 1'b0; k++) wait_n(1);
		end
		ce_n_o = 1'b1;
		drv_on = 1'b0;
		rw_o = 1'b1;
		wait_n(4);
	endtask
endmodule

// >>> rtc_bus_calendar_core_tb.sv
// self-checking bench for the bus calendar core
`timescale 1ns/1ps
module rtc_bus_calendar_core_tb;
	localparam int USER_RAM_CLEAR_N = 50;
	typedef struct packed {
		logic [6:0] a;
		logic [7:0] d;
		logic [7:0] m;
		logic [7:0] e;
	} row_t;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       dev_rst_n = 1'b1;
	logic       clr_n = 1'b1;
	logic [7:0] bus;
	logic [7:0] dq;
	logic       dq_oe;
	logic       style;
	logic       as;
	logic       ds;
	logic       rw;
	logic       ce_n;
	logic       square_wave_out;
	logic       irq_d;
	logic       irq_oe;
	logic [7:0] q;
	logic       g;
	int         errors = 0;
	int         checks_done = 0;
	int         toggles = 0;
	int         i;
	row_t       rows[7] = '{
		'{7'h0e, 8'h5a, 8'hff, 8'h5a}, '{7'h7f, 8'ha5, 8'hff, 8'ha5},
		'{7'h00, 8'h59, 8'hff, 8'h59}, '{7'h03, 8'h59, 8'hff, 8'h59},
		'{7'h09, 8'h99, 8'hff, 8'h99}, '{7'h0d, 8'h00, 8'hff, 8'h80},
		'{7'h0a, 8'haf, 8'h7f, 8'h2f}};
	always #4 clk = ~clk;
	always @(square_wave_out) toggles++;
	rtc_bus_calendar_core #(.SEC_CYC(2000), .RCL_CYC(USER_RAM_CLEAR_N), .UIP_CYC(20)) i_rtc_bus_calendar_core (
		.clk_i(clk), .arst_n_i(arst_n), .shared_addr_data_lines_i(bus),
		.shared_addr_data_lines_o(dq), .shared_addr_data_lines_oe_o(dq_oe),
		.address_latch_strobe_i(as), .data_read_strobe_i(ds), .read_write_i(rw),
		.chip_enable_n_i(ce_n), .bus_style_select_i(style), .device_reset_n_i(dev_rst_n),
		.user_ram_clear_n_i(clr_n), .square_wave_out_o(square_wave_out), .irq_req_i(irq_oe ? irq_d : 1'b1),
		.irq_req_o(irq_d), .irq_req_oe_o(irq_oe));
	rtc_host_model i_rtc_host_model (
		.clk_i(clk), .dev_d_i(dq), .dev_oe_i(dq_oe), .bus_o(bus), .style_o(style),
		.as_o(as), .ds_o(ds), .rw_o(rw), .ce_n_o(ce_n));
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
		checks_done++;
		if ((got & m) !== (exp & m)) begin
			errors++;
			$display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		i_rtc_host_model.wait_n(n);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_rtc_host_model.access(1'b1, 1'b1, a, d, q, g);
	endtask
	task automatic rd(input logic [6:0] a);
		i_rtc_host_model.access(1'b0, 1'b1, a, 8'h00, q, g);
		chk1(g, 1'b1); // drivers on for a read
	endtask
	task automatic wait_irq(input logic lvl);
		for (int k = 0; k < 3000 && irq_oe !== lvl; k++) step(1);
	endtask
	task close_out;
		$display("checks %0d, errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#720000;
		errors++;
		close_out;
	end
	initial begin
		step(4);
		arst_n = 1'b1;
		step(4);
		rd(7'h0b); chk8(q, 8'h02, 8'hff); // hour format after reset
		rd(7'h0d); chk8(q, 8'h80, 8'hff); // fixed status byte
		$display("reset test done");
		wr(7'h0b, 8'h82);
		for (i = 0; i < 7; i++) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a); chk8(q, rows[i].e, rows[i].m); // map and access kinds
		end
		$display("table test done");
		wr(7'h20, 8'h22);
		i_rtc_host_model.access(1'b1, 1'b0, 7'h20, 8'h11, q, g);
		i_rtc_host_model.access(1'b0, 1'b0, 7'h20, 8'h00, q, g);
		chk1(g, 1'b0); // no read without enable
		rd(7'h20); chk8(q, 8'h22, 8'hff); // write without enable lost
		$display("chip enable test done");
		wr(7'h02, 8'h00);
		wr(7'h01, 8'hc0);
		wr(7'h03, 8'hc0);
		wr(7'h05, 8'hc0);
		wr(7'h0b, 8'h02);
		q = 8'h00;
		for (i = 0; i < 100 && q[4] !== 1'b1; i++) rd(7'h0c);
		chk1(q[4], 1'b1); // flag set while disabled
		chk1(irq_oe, 1'b0); // no request while disabled
		rd(7'h00); chk8(q, 8'h00, 8'hff); // seconds wrap
		rd(7'h02); chk8(q, 8'h01, 8'hff); // minute carry in BCD
		$display("time advance test done");
		wr(7'h0b, 8'h22);
		wait_irq(1'b1);
		chk1(irq_oe, 1'b1); // alarm request
		rd(7'h0c); chk8(q, 8'ha0, 8'ha0); // summary and alarm flags
		step(1);
		chk1(irq_oe, 1'b0); // released by status read
		$display("alarm test done");
		wr(7'h0a, 8'h23);
		toggles = 0;
		step(3 * rtc_pkg::TAP_CYCLES);
		chk1(toggles == 0, 1'b1); // output gated off
		wr(7'h0b, 8'h2a);
		toggles = 0;
		step(12 * rtc_pkg::TAP_CYCLES);
		chk1(toggles > 4, 1'b1); // output runs when enabled
		$display("square wave test done");
		wr(7'h0a, 8'h2f);
		wait_irq(1'b1);
		dev_rst_n = 1'b0;
		step(4);
		chk1(irq_oe, 1'b0); // request floated
		i_rtc_host_model.access(1'b1, 1'b1, 7'h0e, 8'h33, q, g);
		i_rtc_host_model.access(1'b0, 1'b1, 7'h0b, 8'h00, q, g);
		chk1(g, 1'b0); // bus ignored in reset
		dev_rst_n = 1'b1;
		step(4);
		rd(7'h0b); chk8(q, 8'h02, 8'hff); // enables cleared
		rd(7'h0c); chk8(q, 8'h00, 8'hf0); // flags cleared
		rd(7'h0e); chk8(q, 8'h5a, 8'hff); // write refused
		$display("device reset test done");
		clr_n = 1'b0;
		step(USER_RAM_CLEAR_N + 114 + 40);
		clr_n = 1'b1;
		step(4);
		rd(7'h0e); chk8(q, 8'hff, 8'hff); // first user byte
		rd(7'h7f); chk8(q, 8'hff, 8'hff); // last user byte
		rd(7'h20); chk8(q, 8'hff, 8'hff); // middle user byte
		rd(7'h0b); chk8(q, 8'h02, 8'hff); // control untouched
		$display("ram clear test done");
		wr(7'h0b, 8'h80);
		wr(7'h04, 8'h91);
		wr(7'h02, 8'h59);
		wr(7'h00, 8'h59);
		rd(7'h0c);
		wr(7'h0b, 8'h00);
		q = 8'h00;
		for (i = 0; i < 100 && q[4] !== 1'b1; i++) rd(7'h0c);
		rd(7'h04); chk8(q, 8'h12, 8'hff); // eleven pm rolls to twelve am
		$display("twelve hour test done");
		i_rtc_host_model.set_style(1'b1);
		wr(7'h30, 8'h3c);
		rd(7'h30); chk8(q, 8'h3c, 8'hff); // strobe and direction style
		$display("bus style test done");
		close_out;
	end
endmodule
